// *** lchs_sequencer.sv ***
// What this block does
// - A clear erases the peak, turns comparison outputs off, optionally zeroes the display.
// - Clear acts once, on the high-to-low edge of the clear terminal only.
// - Arrival mode: above terminal shows above or below, pass kept, below becomes arrival.
// - Arrival mode: arrival flag and lamp are on when the displayed value reaches the arrival value.
// - Point-hold sequencing runs only in one-point or two-point mode.
// - Mode setting encodes off, two-point setting and one-point setting.
// - Above if value exceeds upper limit, pass if within inclusive, below if under lower.
// - A clear releases the held result and the held measured value.
// - Compare on a strobe falling edge, the first strobe in two-point mode only, showing strobe number and its limits.
// - After the second-strobe compare, freeze value and result, ignore strobes until clear.
// - Peak mode: first compare uses peak since clear, then measured values restart.
// - Peak input going high during first compare returns the display to the live reading.
// - Two-point: first pass only on lamps; above or below also on terminals, held.
// - Two-point: second result reaches the terminals when the first was above or below.
// - Clear during a sequence releases result, shows selected pattern, dashes the limits.
// - One-point: second-strobe result drives the terminals directly.
// - Check view shows stored results on lamps only; dashes if none; clear erases them.
// - Analog output is 10 V at the top value and 0 V at the bottom value.
// - Top and bottom accepted from -9999 to 9999 in either order.
// - Beyond top or positive over-range gives about 11 V; negative over-range gives 0 V.
// - Analog output is 0 V while settings are being edited.
// - Power-on lights all indicators, output 0 V, operable after about 3 seconds.
`include "lchs_params.svh"
`default_nettype none
module lchs_sequencer #(
   parameter int unsigned STARTUP_CYCLES = `LCHS_STARTUP_S * `LCHS_CLK_HZ,
   parameter int unsigned VALUE_W        = 16
) (
   // Clock and reset
   input  wire logic                      clk_i,
   input  wire logic                      reset_n_i,
   // APB slave
   input  wire logic                      psel_i,
   input  wire logic                      penable_i,
   input  wire logic                      pwrite_i,
   input  wire logic [7:0]                paddr_i,
   input  wire logic [31:0]               pwdata_i,
   output logic      [31:0]               prdata_o,
   output logic                           pready_o,
   output logic                           pslverr_o,
   // Contact inputs, low active
   input  wire logic                      clear_terminal_n_i,
   input  wire logic                      peak_hold_input_n_i,
   input  wire logic                      first_compare_strobe_n_i,
   input  wire logic                      second_compare_strobe_n_i,
   // Measurement
   input  wire logic signed [VALUE_W-1:0] measured_i,
   input  wire logic                      over_pos_i,
   input  wire logic                      over_neg_i,
   // Comparison terminals
   output logic                           term_above_o,
   output logic                           term_pass_o,
   output logic                           term_below_o,
   // Monitor lamps and displays
   output logic                           lamp_above_o,
   output logic                           lamp_pass_o,
   output logic                           lamp_below_o,
   output logic                           arrival_lamp_o,
   output logic                           all_lamps_o,
   output logic      [1:0]                pattern_disp_o,
   output logic                           limit_dashes_o,
   output logic                           main_dashes_o,
   output logic signed [VALUE_W-1:0]      disp_value_o,
   output logic signed [VALUE_W-1:0]      limit_hi_disp_o,
   output logic signed [VALUE_W-1:0]      limit_lo_disp_o,
   // Analog output level in millivolts, and operable flag
   output logic      [15:0]               analog_mv_o,
   output logic                           ready_o
);

   typedef logic signed [VALUE_W-1:0] lchs_val_t;

   // Register file
   logic [`LCHS_CTRL_W-1:0] ctrl_q, ctrl_d;
   logic [31:0]             e1_lim_q, e1_lim_d, e2_lim_q, e2_lim_d, analog_q, analog_d;
   logic [15:0]             arrival_q, arrival_d;
   logic [31:0]             prdata_d;
   logic                    addr_ok;

   // Sequencer state
   lchs_pkg::lchs_seq_t     seq_q, seq_d;
   lchs_pkg::lchs_result_t res1_q, res1_d, res2_q, res2_d, term_q, term_d, lamp_q, lamp_d;
   lchs_val_t               peak_q, peak_d, held_q, held_d, meas1_q, meas1_d;
   logic [1:0]              pat_q, pat_d;
   logic                    zero_q, zero_d;
   logic                    clr_prev_q, e1_prev_q, e2_prev_q;
   logic [31:0]             boot_q, boot_d;
   logic [15:0]             ao_q, ao_d;

   logic [1:0]              mode;
   logic                    hold_on, peak_on, clr_fall, e1_fall, e2_fall, ready, arrival;
   lchs_val_t               cmp_val, live_val, disp_val;
   lchs_pkg::lchs_result_t  res_now, chk_res, out_res;

   function automatic lchs_pkg::lchs_result_t compare(input lchs_val_t v, input logic [31:0] lim);
      lchs_val_t hi;
      lchs_val_t lo;
      hi = lim[31:16];
      lo = lim[15:0];
      if (v > hi) begin
         compare = lchs_pkg::LCHS_RES_ABOVE;
      end else if (v < lo) begin
         compare = lchs_pkg::LCHS_RES_BELOW;
      end else begin
         compare = lchs_pkg::LCHS_RES_PASS;
      end
   endfunction : compare

   // APB slave, zero wait state, read data loaded in the setup cycle
   always_comb begin
      ctrl_d    = ctrl_q;
      e1_lim_d  = e1_lim_q;
      e2_lim_d  = e2_lim_q;
      arrival_d = arrival_q;
      analog_d  = analog_q;
      prdata_d  = prdata_o;
      addr_ok   = 1'b1;
      if (paddr_i == `LCHS_CTRL_OFS) begin
         prdata_d = {25'h0, ctrl_q};
         if (psel_i && penable_i && pwrite_i) ctrl_d = pwdata_i[`LCHS_CTRL_W-1:0];
      end else if (paddr_i == `LCHS_E1_LIM_OFS) begin
         prdata_d = e1_lim_q;
         if (psel_i && penable_i && pwrite_i) e1_lim_d = pwdata_i;
      end else if (paddr_i == `LCHS_E2_LIM_OFS) begin
         prdata_d = e2_lim_q;
         if (psel_i && penable_i && pwrite_i) e2_lim_d = pwdata_i;
      end else if (paddr_i == `LCHS_ARRIVAL_OFS) begin
         prdata_d = {16'h0, arrival_q};
         if (psel_i && penable_i && pwrite_i) arrival_d = pwdata_i[15:0];
      end else if (paddr_i == `LCHS_ANALOG_OFS) begin
         prdata_d = analog_q;
         if (psel_i && penable_i && pwrite_i) analog_d = pwdata_i;
      end else if (paddr_i == `LCHS_STATUS_OFS) begin
         prdata_d = {22'h0, ready, zero_q, seq_q, term_q, res2_q, res1_q};
      end else if (paddr_i == `LCHS_VALUE_OFS) begin
         prdata_d = {{(32-VALUE_W){disp_val[VALUE_W-1]}}, disp_val};
      end else begin
         prdata_d = 32'h0000_0000;
         addr_ok  = 1'b0;
      end
      if (!(psel_i && !penable_i)) prdata_d = prdata_o;
   end

   assign pready_o  = psel_i & penable_i;
   assign pslverr_o = psel_i & penable_i & ~addr_ok;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl_q    <= `LCHS_CTRL_RST;
         e1_lim_q  <= `LCHS_LIM_RST;
         e2_lim_q  <= `LCHS_LIM_RST;
         arrival_q <= `LCHS_ARRIVAL_RST;
         analog_q  <= `LCHS_ANALOG_RST;
         prdata_o  <= 32'h0000_0000;
      end else begin
         ctrl_q    <= ctrl_d;
         e1_lim_q  <= e1_lim_d;
         e2_lim_q  <= e2_lim_d;
         arrival_q <= arrival_d;
         analog_q  <= analog_d;
         prdata_o  <= prdata_d;
      end
   end

   // Input edges and shared terms
   assign mode     = ctrl_q[`LCHS_CTRL_MODE_HI:`LCHS_CTRL_MODE_LO];
   assign hold_on  = (mode == `LCHS_MODE_TWO) || (mode == `LCHS_MODE_ONE);
   assign peak_on  = ~peak_hold_input_n_i;
   assign ready    = (boot_q >= STARTUP_CYCLES);
   assign clr_fall = ready & clr_prev_q & ~clear_terminal_n_i;
   assign e1_fall  = ready & e1_prev_q & ~first_compare_strobe_n_i;
   assign e2_fall  = ready & e2_prev_q & ~second_compare_strobe_n_i;
   assign live_val = measured_i;
   assign cmp_val  = (peak_on && peak_q > live_val) ? peak_q : live_val;

   // Sequencer next state
   always_comb begin
      seq_d   = seq_q;
      res1_d  = res1_q;
      res2_d  = res2_q;
      term_d  = term_q;
      lamp_d  = lamp_q;
      held_d  = held_q;
      meas1_d = meas1_q;
      pat_d   = pat_q;
      zero_d  = zero_q;
      boot_d  = ready ? boot_q : boot_q + 32'h1;
      res_now = lchs_pkg::LCHS_RES_NONE;
      peak_d  = (peak_on && live_val > peak_q) ? live_val : peak_q;
      if (clr_fall) begin
         peak_d  = live_val;
         term_d  = lchs_pkg::LCHS_RES_NONE;
         lamp_d  = lchs_pkg::LCHS_RES_NONE;
         res1_d  = lchs_pkg::LCHS_RES_NONE;
         res2_d  = lchs_pkg::LCHS_RES_NONE;
         seq_d   = lchs_pkg::LCHS_SQ_IDLE;
         pat_d   = 2'h0;
         zero_d  = ctrl_q[`LCHS_CTRL_CZD];
      end else if (hold_on && seq_q != lchs_pkg::LCHS_SQ_HELD) begin
         if (e2_fall) begin
            res_now = compare(cmp_val, e2_lim_q);
            res2_d  = res_now;
            lamp_d  = res_now;
            held_d  = cmp_val;
            pat_d   = 2'h2;
            zero_d  = 1'b0;
            seq_d   = lchs_pkg::LCHS_SQ_HELD;
            if (mode == `LCHS_MODE_ONE) begin
               term_d = res_now;
            end else if (res1_q == lchs_pkg::LCHS_RES_ABOVE ||
                         res1_q == lchs_pkg::LCHS_RES_BELOW) begin
               term_d = res_now;
            end else begin
               term_d = lchs_pkg::LCHS_RES_NONE;
            end
         end else if (e1_fall && mode == `LCHS_MODE_TWO &&
                      seq_q == lchs_pkg::LCHS_SQ_IDLE) begin
            res_now = compare(cmp_val, e1_lim_q);
            res1_d  = res_now;
            lamp_d  = res_now;
            meas1_d = cmp_val;
            pat_d   = 2'h1;
            zero_d  = 1'b0;
            peak_d  = live_val;
            seq_d   = lchs_pkg::LCHS_SQ_FIRST_DONE;
            if (res_now != lchs_pkg::LCHS_RES_PASS) term_d = res_now;
         end
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         seq_q      <= lchs_pkg::LCHS_SQ_IDLE;
         res1_q     <= lchs_pkg::LCHS_RES_NONE;
         res2_q     <= lchs_pkg::LCHS_RES_NONE;
         term_q     <= lchs_pkg::LCHS_RES_NONE;
         lamp_q     <= lchs_pkg::LCHS_RES_NONE;
         peak_q     <= '0;
         held_q     <= '0;
         meas1_q    <= '0;
         pat_q      <= 2'h0;
         zero_q     <= 1'b0;
         boot_q     <= 32'h0000_0000;
         clr_prev_q <= 1'b1;
         e1_prev_q  <= 1'b1;
         e2_prev_q  <= 1'b1;
      end else begin
         seq_q      <= seq_d;
         res1_q     <= res1_d;
         res2_q     <= res2_d;
         term_q     <= term_d;
         lamp_q     <= lamp_d;
         peak_q     <= peak_d;
         held_q     <= held_d;
         meas1_q    <= meas1_d;
         pat_q      <= pat_d;
         zero_q     <= zero_d;
         boot_q     <= boot_d;
         clr_prev_q <= clear_terminal_n_i;
         e1_prev_q  <= first_compare_strobe_n_i;
         e2_prev_q  <= second_compare_strobe_n_i;
      end
   end

   // Display selection and output mapping
   always_comb begin
      if (seq_q == lchs_pkg::LCHS_SQ_HELD) begin
         disp_val = held_q;
      end else if (zero_q) begin
         disp_val = '0;
      end else if (peak_on) begin
         disp_val = cmp_val;
      end else begin
         disp_val = live_val;
      end
      chk_res = ctrl_q[`LCHS_CTRL_CHK_SEL] ? res2_q : res1_q;
      out_res = ctrl_q[`LCHS_CTRL_CHECK] ? chk_res : lamp_q;
   end

   assign arrival = ctrl_q[`LCHS_CTRL_ARR_EN] && (disp_val >= $signed(arrival_q));

   // Analog scaling
   always_comb begin
      logic signed [31:0] num;
      logic signed [31:0] den;
      logic signed [31:0] lvl;
      num  = 32'(disp_val - $signed(analog_q[15:0])) * `LCHS_AO_FULL_MV;
      den  = 32'($signed(analog_q[31:16])) - 32'($signed(analog_q[15:0]));
      lvl  = (den == 32'sd0) ? 32'sd0 : num / den;
      ao_d = 16'(lvl);
      if (!ready || ctrl_q[`LCHS_CTRL_EDIT] || over_neg_i) begin
         ao_d = `LCHS_AO_ZERO_MV;
      end else if (over_pos_i || lvl > `LCHS_AO_FULL_MV) begin
         ao_d = `LCHS_AO_OVER_MV;
      end else if (lvl < 32'sd0) begin
         ao_d = `LCHS_AO_ZERO_MV;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ao_q <= `LCHS_AO_ZERO_MV;
      end else begin
         ao_q <= ao_d;
      end
   end

   // Terminal outputs, remapped when arrival mode is on
   always_comb begin
      if (ctrl_q[`LCHS_CTRL_ARR_EN]) begin
         term_above_o = (term_q == lchs_pkg::LCHS_RES_ABOVE) ||
                        (term_q == lchs_pkg::LCHS_RES_BELOW);
         term_below_o = arrival;
      end else begin
         term_above_o = (term_q == lchs_pkg::LCHS_RES_ABOVE);
         term_below_o = (term_q == lchs_pkg::LCHS_RES_BELOW);
      end
      term_pass_o = (term_q == lchs_pkg::LCHS_RES_PASS);
   end

   assign all_lamps_o     = ~ready;
   assign lamp_above_o    = ~ready | (out_res == lchs_pkg::LCHS_RES_ABOVE);
   assign lamp_pass_o     = ~ready | (out_res == lchs_pkg::LCHS_RES_PASS);
   assign lamp_below_o    = ~ready | (out_res == lchs_pkg::LCHS_RES_BELOW);
   assign arrival_lamp_o  = ~ready | arrival;
   assign pattern_disp_o  = pat_q;
   assign limit_dashes_o  = (pat_q == 2'h0);
   assign main_dashes_o   = ctrl_q[`LCHS_CTRL_CHECK] &&
                            (chk_res == lchs_pkg::LCHS_RES_NONE);
   assign disp_value_o    = (ctrl_q[`LCHS_CTRL_CHECK] && ctrl_q[`LCHS_CTRL_CHK_SEL]) ? held_q :
                            ctrl_q[`LCHS_CTRL_CHECK] ? meas1_q : disp_val;
   assign limit_hi_disp_o = (pat_q == 2'h2) ? e2_lim_q[31:16] : e1_lim_q[31:16];
   assign limit_lo_disp_o = (pat_q == 2'h2) ? e2_lim_q[15:0] : e1_lim_q[15:0];
   assign analog_mv_o     = ao_q;
   assign ready_o         = ready;

endmodule : lchs_sequencer
`default_nettype wire

// *** lchs_params.svh ***
`ifndef LCHS_PARAMS_SVH
`define LCHS_PARAMS_SVH

// Register byte offsets
`define LCHS_CTRL_OFS      8'h00
`define LCHS_E1_LIM_OFS    8'h04
`define LCHS_E2_LIM_OFS    8'h08
`define LCHS_ARRIVAL_OFS   8'h0C
`define LCHS_ANALOG_OFS    8'h10
`define LCHS_STATUS_OFS    8'h14
`define LCHS_VALUE_OFS     8'h18

// Control register fields
`define LCHS_CTRL_MODE_LO  0
`define LCHS_CTRL_MODE_HI  1
`define LCHS_CTRL_CZD      2
`define LCHS_CTRL_ARR_EN   3
`define LCHS_CTRL_EDIT     4
`define LCHS_CTRL_CHECK    5
`define LCHS_CTRL_CHK_SEL  6
`define LCHS_CTRL_W        7
`define LCHS_CTRL_RST      7'h00

// Mode codes of the point-hold mode setting
`define LCHS_MODE_OFF      2'h0
`define LCHS_MODE_TWO      2'h1
`define LCHS_MODE_ONE      2'h2

// Reset values of limits and scaling
`define LCHS_LIM_RST       32'h03E8_01F4
`define LCHS_ARRIVAL_RST   16'h03E8
`define LCHS_ANALOG_RST    32'h2710_0000

// Analog levels in millivolts
`define LCHS_AO_FULL_MV    32'sd10000
`define LCHS_AO_OVER_MV    16'h2AF8
`define LCHS_AO_ZERO_MV    16'h0000

// Power-on timing
`define LCHS_STARTUP_S     3
`define LCHS_CLK_HZ        20000000

`endif

// *** lchs_pkg.sv ***
`default_nettype none
package lchs_pkg;

   typedef enum logic [1:0] {
      LCHS_RES_NONE,
      LCHS_RES_ABOVE,
      LCHS_RES_PASS,
      LCHS_RES_BELOW
   } lchs_result_t;

   typedef enum logic [1:0] {
      LCHS_SQ_IDLE,
      LCHS_SQ_FIRST_DONE,
      LCHS_SQ_HELD
   } lchs_seq_t;

endpackage : lchs_pkg
`default_nettype wire

// *** lchs_sequencer_assertions.sv ***
`default_nettype none
module lchs_sequencer_assertions (
   // Clock and reset
   input wire logic        clk_i,
   input wire logic        reset_n_i,
   // Watched inputs
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        clear_terminal_n_i,
   input wire logic        over_neg_i,
   // Watched outputs
   input wire logic        pready_o,
   input wire logic        term_above_o,
   input wire logic        term_pass_o,
   input wire logic        lamp_above_o,
   input wire logic        lamp_pass_o,
   input wire logic        lamp_below_o,
   input wire logic        all_lamps_o,
   input wire logic [1:0]  pattern_disp_o,
   input wire logic        limit_dashes_o,
   input wire logic [15:0] analog_mv_o,
   input wire logic        ready_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   property p_clr_off; ready_o && $fell(clear_terminal_n_i) |=> !term_above_o && !term_pass_o; endproperty
   a_clr_off: assert property (p_clr_off) else $error("terminal on after clear");
   property p_clr_pat; ready_o && $fell(clear_terminal_n_i) |=> pattern_disp_o == 2'h0 && limit_dashes_o; endproperty
   a_clr_pat: assert property (p_clr_pat) else $error("no dashes after clear");
   // A register write may remap the terminals, so the access edge is left out
   property p_held;
      ready_o && pattern_disp_o == 2'h2 && clear_terminal_n_i && !(psel_i && penable_i)
      |=> $stable({term_above_o, term_pass_o});
   endproperty
   a_held: assert property (p_held) else $error("held result moved");
   property p_boot; !ready_o |-> all_lamps_o && analog_mv_o == 16'h0000; endproperty
   a_boot: assert property (p_boot) else $error("startup state wrong");
   property p_neg; ready_o && over_neg_i [*3] |-> analog_mv_o == 16'h0000; endproperty
   a_neg: assert property (p_neg) else $error("negative over not zero");
   property p_span; analog_mv_o <= 16'h2710 || analog_mv_o == 16'h2AF8; endproperty
   a_span: assert property (p_span) else $error("analog level out of span");
   property p_lamps; ready_o |-> $onehot0({lamp_above_o, lamp_pass_o, lamp_below_o}); endproperty
   a_lamps: assert property (p_lamps) else $error("two result lamps lit");
   property p_apb; pready_o == (psel_i && penable_i); endproperty
   a_apb: assert property (p_apb) else $error("pready not in access phase");
endmodule : lchs_sequencer_assertions

bind lchs_sequencer lchs_sequencer_assertions u_chk (
   .clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
   .clear_terminal_n_i(clear_terminal_n_i), .over_neg_i(over_neg_i), .pready_o(pready_o),
   .term_above_o(term_above_o), .term_pass_o(term_pass_o), .lamp_above_o(lamp_above_o),
   .lamp_pass_o(lamp_pass_o), .lamp_below_o(lamp_below_o), .all_lamps_o(all_lamps_o),
   .pattern_disp_o(pattern_disp_o), .limit_dashes_o(limit_dashes_o),
   .analog_mv_o(analog_mv_o), .ready_o(ready_o)
);
`default_nettype wire

// *** lchs_contacts.sv ***
`default_nettype none
module lchs_contacts (
   // Clock
   input  wire logic          clk_i,
   // Contact lines, pulled up while open
   output logic               clear_n_o,
   output logic               peak_n_o,
   output logic               first_n_o,
   output logic               second_n_o,
   // Load seen by the front end
   output logic signed [15:0] measured_o,
   output logic               over_pos_o,
   output logic               over_neg_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      clear_n_o  = 1'b1;
      peak_n_o   = 1'b1;
      first_n_o  = 1'b1;
      second_n_o = 1'b1;
      measured_o = 16'sh0000;
      over_pos_o = 1'b0;
      over_neg_o = 1'b0;
   end
   // Line 0 clear, 1 first strobe, 2 second strobe, 3 peak hold
   task automatic drive(input int line, input logic level);
      @(posedge clk_i);
      case (line)
         0: clear_n_o <= level;
         1: first_n_o <= level;
         3: peak_n_o <= level;
         default: second_n_o <= level;
      endcase
   endtask : drive
   // Closure of three cycles, then open long enough for the result to land
   task automatic press(input int line);
      drive(line, 1'b0);
      repeat (2) @(posedge clk_i);
      drive(line, 1'b1);
      repeat (2) @(posedge clk_i);
   endtask : press
   task automatic load(input logic signed [15:0] v, input logic neg);
      @(posedge clk_i);
      measured_o <= v;
      over_neg_o <= neg;
   endtask : load
   task automatic range_flags(input logic pos, input logic neg);
      @(posedge clk_i);
      over_pos_o <= pos;
      over_neg_o <= neg;
   endtask : range_flags
endmodule : lchs_contacts
`default_nettype wire

// *** testbench.sv ***
`include "lchs_params.svh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic               clk_i = 1'b0;
   logic               reset_n_i = 1'b0;
   logic               psel_i = 1'b0;
   logic               penable_i = 1'b0;
   logic               pwrite_i = 1'b0;
   logic        [7:0]  paddr_i = 8'h00;
   logic        [31:0] pwdata_i = 32'h0000_0000;
   logic        [31:0] prdata_o;
   logic        [31:0] rd;
   logic               pready_o, pslverr_o, err, clr_n, pk_n, e1_n, e2_n, ov_p, ov_n;
   logic signed [15:0] meas, disp, lim_hi, lim_lo;
   logic               t_ab, t_pa, t_be, l_ab, l_pa, l_be, arr, all_l, dash, m_dash, rdy;
   logic        [1:0]  pat;
   logic        [15:0] ao;
   int                 n_fail = 0;
   int                 n_checks = 0;
   int                 cyc = 0;
   always #25 clk_i = ~clk_i;
   lchs_sequencer #(.STARTUP_CYCLES(20)) u_dut (
      .clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
      .pready_o, .pslverr_o, .clear_terminal_n_i(clr_n), .peak_hold_input_n_i(pk_n),
      .first_compare_strobe_n_i(e1_n), .second_compare_strobe_n_i(e2_n), .measured_i(meas),
      .over_pos_i(ov_p), .over_neg_i(ov_n), .term_above_o(t_ab), .term_pass_o(t_pa),
      .term_below_o(t_be), .lamp_above_o(l_ab), .lamp_pass_o(l_pa), .lamp_below_o(l_be),
      .arrival_lamp_o(arr), .all_lamps_o(all_l), .pattern_disp_o(pat), .limit_dashes_o(dash),
      .main_dashes_o(m_dash), .disp_value_o(disp), .limit_hi_disp_o(lim_hi),
      .limit_lo_disp_o(lim_lo), .analog_mv_o(ao), .ready_o(rdy)
   );
   lchs_contacts u_ct (
      .clk_i, .clear_n_o(clr_n), .peak_n_o(pk_n), .first_n_o(e1_n), .second_n_o(e2_n),
      .measured_o(meas), .over_pos_o(ov_p), .over_neg_o(ov_n)
   );
   task automatic end_sim();
      if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_sim
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel_i    <= 1'b1;
      pwrite_i  <= wr;
      paddr_i   <= a;
      pwdata_i  <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      @(posedge clk_i);
      while (pready_o !== 1'b1) @(posedge clk_i);
      rd = prdata_o;
      err = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb
   task automatic t_boot();
      check("all_lamps", all_l, 1'b1);
      for (int i = 0; i < 100 && rdy !== 1'b1; i++) @(posedge clk_i);
      check("ready", rdy, 1'b1);
      apb(1'b0, `LCHS_E1_LIM_OFS, 32'h0);
      check("e1_limits", rd, 32'h03E8_01F4);
      apb(1'b0, 8'h1C, 32'h0);
      check("unmapped_err", err, 1'b1);
   endtask : t_boot
   task automatic t_two_point();
      apb(1'b1, `LCHS_CTRL_OFS, 32'h5);
      u_ct.load(16'sd1200, 1'b0);
      u_ct.press(0);
      check("zero_disp", disp, 32'h0);
      u_ct.press(1);
      check("pattern", pat, 2'h1);
      check("limit_hi", lim_hi, 32'h3E8);
      check("limit_lo", lim_lo, 32'h1F4);
      check("term_above", t_ab, 1'b1);
      u_ct.load(16'sd700, 1'b0);
      u_ct.press(2);
      check("term_pass", t_pa, 1'b1);
      u_ct.load(16'sd300, 1'b0);
      u_ct.press(2);
      check("held_disp", disp, 32'd700);
      apb(1'b0, `LCHS_VALUE_OFS, 32'h0);
      check("value_reg", rd, 32'd700);
      apb(1'b1, `LCHS_CTRL_OFS, 32'h25);
      repeat (2) @(posedge clk_i);
      check("view_lamp", l_ab, 1'b1);
      check("view_term", t_pa, 1'b1);
      u_ct.drive(0, 1'b0);
      repeat (3) @(posedge clk_i);
      check("clr_term", t_pa, 1'b0);
      check("clr_dash", dash, 1'b1);
      check("view_dash", m_dash, 1'b1);
      apb(1'b1, `LCHS_CTRL_OFS, 32'h1);
      u_ct.press(1);
      check("clr_low_once", pat, 2'h1);
      u_ct.drive(0, 1'b1);
   endtask : t_two_point
   task automatic t_order();
      u_ct.press(0);
      u_ct.load(16'sd700, 1'b0);
      u_ct.press(2);
      check("e2_first", t_pa, 1'b0);
      u_ct.press(0);
      u_ct.press(1);
      check("pass_lamp", l_pa, 1'b1);
      check("pass_term", t_pa, 1'b0);
   endtask : t_order
   task automatic t_modes();
      apb(1'b1, `LCHS_CTRL_OFS, 32'h2);
      u_ct.press(0);
      u_ct.load(16'sd400, 1'b0);
      u_ct.press(1);
      check("e1_ignored", pat, 2'h0);
      u_ct.press(2);
      check("term_below", t_be, 1'b1);
      check("lamp_below", l_be, 1'b1);
      apb(1'b1, `LCHS_CTRL_OFS, 32'hA);
      u_ct.press(0);
      u_ct.load(16'sd1000, 1'b0);
      repeat (3) @(posedge clk_i);
      check("arrival", {t_be, arr}, 2'h3);
      u_ct.load(16'sd400, 1'b0);
      u_ct.press(2);
      check("below_as_above", {t_ab, t_be}, 2'h2);
      apb(1'b1, `LCHS_CTRL_OFS, 32'h0);
      u_ct.press(0);
      u_ct.press(2);
      check("off_pattern", pat, 2'h0);
   endtask : t_modes
   task automatic t_peak();
      apb(1'b1, `LCHS_CTRL_OFS, 32'h1);
      u_ct.drive(3, 1'b0);
      u_ct.press(0);
      u_ct.load(16'sd1200, 1'b0);
      u_ct.load(16'sd600, 1'b0);
      u_ct.press(1);
      check("peak_cmp", t_ab, 1'b1);
      u_ct.load(16'sd900, 1'b0);
      u_ct.load(16'sd650, 1'b0);
      repeat (2) @(posedge clk_i);
      check("peak_disp", disp, 32'd900);
      u_ct.drive(3, 1'b1);
      repeat (2) @(posedge clk_i);
      check("live_disp", disp, 32'd650);
   endtask : t_peak
   task automatic t_analog();
      logic signed [15:0] m [4] = '{16'sd1000, 16'sd100, 16'sd550, 16'sd1100};
      logic        [15:0] e [4] = '{16'h2710, 16'h0000, 16'h1388, 16'h2AF8};
      apb(1'b1, `LCHS_ANALOG_OFS, 32'h03E8_0064);
      for (int i = 0; i < 4; i++) begin
         u_ct.load(m[i], 1'b0);
         repeat (5) @(posedge clk_i);
         check("analog", ao, e[i]);
      end
      apb(1'b1, `LCHS_ANALOG_OFS, 32'h0064_03E8);
      u_ct.load(16'sd100, 1'b0);
      repeat (5) @(posedge clk_i);
      check("analog_inv", ao, 16'h2710);
      apb(1'b1, `LCHS_CTRL_OFS, 32'h10);
      repeat (3) @(posedge clk_i);
      check("analog_edit", ao, 16'h0000);
      apb(1'b1, `LCHS_CTRL_OFS, 32'h0);
      u_ct.load(16'sd100, 1'b1);
      repeat (5) @(posedge clk_i);
      check("analog_neg", ao, 16'h0000);
      u_ct.range_flags(1'b1, 1'b0);
      repeat (5) @(posedge clk_i);
      check("analog_pos", ao, 16'h2AF8);
   endtask : t_analog
   // Cuts a hung wait short
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         n_fail++;
         end_sim();
      end
   end
   initial begin
      repeat (12) @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(posedge clk_i);
      t_boot();
      t_two_point();
      t_order();
      t_modes();
      t_peak();
      t_analog();
      end_sim();
   end
endmodule : testbench
`default_nettype wire
